// ==== verilog/svm_pkg.sv ====
package svm_pkg;

  // Bus geometry: one aligned 32-bit word per register.
  localparam int SVM_ADDR_W = 5;
  localparam int SVM_DATA_W = 32;
  localparam int SVM_BE_W = 4;
  localparam int SVM_REG_W = 8;
  localparam int SVM_IDX_W = 3;
  localparam int SVM_LANE0 = 0;
  localparam int SVM_WORD_SHIFT = 2;

  // Register indices; the byte address is four times the index.
  localparam logic [SVM_IDX_W-1:0] SVM_IDX_ENABLE = 3'h0;
  localparam logic [SVM_IDX_W-1:0] SVM_IDX_STATUS = 3'h1;
  localparam logic [SVM_IDX_W-1:0] SVM_IDX_IRQ_EN = 3'h2;
  localparam logic [SVM_IDX_W-1:0] SVM_IDX_FLAGS = 3'h3;

  // Field positions in the module enable register.
  localparam int SVM_HIGH_SEL_BIT = 6;
  localparam int SVM_LOW_SEL_LSB = 4;
  localparam int SVM_LOW_SEL_MSB = 5;
  localparam int SVM_ADC_EN_BIT = 3;
  localparam int SVM_SENSE_EN_BIT = 2;

  // Field positions shared by status, irq enable and flag registers.
  localparam int SVM_LOW_BIT = 0;
  localparam int SVM_HIGH_BIT = 1;
  localparam int SVM_NUM_COND = 2;

  // Writable bits of each register; all others read as zero.
  localparam logic [SVM_REG_W-1:0] SVM_ENABLE_MASK = 8'h7c;
  localparam logic [SVM_REG_W-1:0] SVM_IRQ_MASK = 8'h03;

  // Reset values.
  localparam logic [SVM_REG_W-1:0] SVM_REG_RESET = 8'h00;
  localparam logic [SVM_DATA_W-1:0] SVM_DATA_RESET = 32'h0000_0000;
  localparam logic [SVM_NUM_COND-1:0] SVM_COND_RESET = 2'h0;
  localparam logic [SVM_DATA_W-SVM_REG_W-1:0] SVM_PAD = 24'h00_0000;

  // Bus handshake state.
  typedef enum logic [0:0] {
    SVM_IDLE = 1'b0,
    SVM_ACK = 1'b1
  } svm_bus_e;

endpackage

// ==== verilog/svm_cond_if.sv ====
`timescale 1ns/1ps
interface svm_cond_if;
  import svm_pkg::*;

  logic sense_en;
  logic [SVM_NUM_COND-1:0] cond;
  logic [SVM_NUM_COND-1:0] change;

  // The sensing side produces conditions; the register side consumes them.
  modport sense (input sense_en, output cond, output change);
  modport regs (output sense_en, input cond, input change);
endinterface

// ==== verilog/svm_cond_sense.sv ====
`timescale 1ns/1ps
module svm_cond_sense (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Raw comparator outputs, asynchronous to the clock.
  input wire logic [svm_pkg::SVM_NUM_COND-1:0] cmp_in,
  // Conditions toward the register file.
  svm_cond_if.sense cond_if
);
  import svm_pkg::*;

  genvar gi;

  // One identical lane per comparator: bit 0 low, bit 1 high.
  generate
    for (gi = 0; gi < SVM_NUM_COND; gi++) begin : g_lane
      logic meta_reg;
      logic sync_reg;
      logic cond_reg;
      logic prev_reg;
      logic meta_next;
      logic sync_next;
      logic cond_next;
      logic prev_next;

      // The first stage feeds only the second stage, so a metastable
      // sample never reaches the gating or the change detector.
      always_comb begin
        meta_next = cmp_in[gi];
        sync_next = meta_reg;
        cond_next = sync_reg & cond_if.sense_en;
        prev_next = cond_reg;
      end

      always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
          cond_reg <= 1'b0;
          prev_reg <= 1'b0;
        end else begin
          meta_reg <= meta_next;
          sync_reg <= sync_next;
          cond_reg <= cond_next;
          prev_reg <= prev_next;
        end
      end

      // A change in either direction, the forced drop included, is seen
      // by comparing with the previous cycle.
      assign cond_if.cond[gi] = cond_reg;
      assign cond_if.change[gi] = cond_reg ^ prev_reg;
    end
  endgenerate

endmodule

// ==== verilog/svm_top.sv ====
// The Avalon-MM interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
// What this block does
// - High flag requests an interrupt only while its enable bit is one.
// - Low flag requests an interrupt only while its enable bit is one.
// - Flags readable anytime; a one-write clears, nothing else clears.
// - High flag sets on any change of the high condition, stays set.
// - Low flag sets on any change of the low condition, stays set.
// - Interrupt output goes low one cycle after stop mode entry and stays low while it lasts.
// - Stop mode entry or exit leaves both flags untouched.
// - Sense enable zero forces both condition bits to zero.
// - Forced drop on sense disable counts as a change and sets flags.
// - Both enabled sources merge into one module interrupt output.
// - Two-bit low threshold select picks one of four low trip levels.
// - One-bit high threshold select picks one of two high trip levels.
// - Sense enable at bit two gates both measurements.
// - Condition status bits are read-only and show current results.
module svm_top (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Avalon-MM register slave.
  input wire logic [svm_pkg::SVM_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [svm_pkg::SVM_DATA_W-1:0] avs_writedata,
  input wire logic [svm_pkg::SVM_BE_W-1:0] avs_byteenable,
  output logic [svm_pkg::SVM_DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Comparator results and analog controls.
  input wire logic low_cmp_in,
  input wire logic high_cmp_in,
  output logic [1:0] low_threshold_select,
  output logic high_threshold_select,
  output logic level_sense_enable,
  output logic adc_connect_enable,
  // System interface.
  input wire logic cpu_stop_mode,
  output logic module_irq
);
  import svm_pkg::*;

  // Word address decode, used by both the read mux and the write path.
  function automatic logic hits(input logic [SVM_ADDR_W-1:0] addr,
                                input logic [SVM_IDX_W-1:0] idx);
    logic [SVM_ADDR_W-1:0] want;
    want = SVM_ADDR_W'(idx) << SVM_WORD_SHIFT;
    hits = (addr == want);
  endfunction

  svm_cond_if cond_if ();

  // Bus handshake state.
  svm_bus_e bus_reg;
  svm_bus_e bus_next;
  logic waitrequest_reg;
  logic waitrequest_next;
  logic [SVM_DATA_W-1:0] readdata_reg;
  logic [SVM_DATA_W-1:0] readdata_next;

  // Software-visible registers.
  logic [SVM_REG_W-1:0] enable_reg;
  logic [SVM_REG_W-1:0] enable_next;
  logic [SVM_REG_W-1:0] irq_en_reg;
  logic [SVM_REG_W-1:0] irq_en_next;
  logic [SVM_REG_W-1:0] flags_reg;
  logic [SVM_REG_W-1:0] flags_next;
  logic irq_reg;
  logic irq_next;

  // Helpers for the write path and read mux.
  logic wr_fire;
  logic [SVM_REG_W-1:0] wr_byte;
  logic [SVM_REG_W-1:0] clr_mask;
  logic [SVM_REG_W-1:0] set_mask;
  logic [SVM_REG_W-1:0] status_byte;
  logic [SVM_REG_W-1:0] rd_byte;

  // The condition lanes only see the sense enable bit of the register.
  assign cond_if.sense_en = enable_reg[SVM_SENSE_EN_BIT];

  svm_cond_sense u_sense (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .cmp_in({high_cmp_in, low_cmp_in}),
    .cond_if(cond_if)
  );

  // Status byte built from the live, already gated conditions.
  always_comb begin
    status_byte = SVM_REG_RESET;
    status_byte[SVM_LOW_BIT] = cond_if.cond[SVM_LOW_BIT];
    status_byte[SVM_HIGH_BIT] = cond_if.cond[SVM_HIGH_BIT];
  end

  // Read mux. Unmapped words, the reserved ones included, read zero.
  always_comb begin
    rd_byte = SVM_REG_RESET;
    if (hits(avs_address, SVM_IDX_ENABLE)) begin
      rd_byte = enable_reg;
    end else if (hits(avs_address, SVM_IDX_STATUS)) begin
      rd_byte = status_byte;
    end else if (hits(avs_address, SVM_IDX_IRQ_EN)) begin
      rd_byte = irq_en_reg;
    end else if (hits(avs_address, SVM_IDX_FLAGS)) begin
      rd_byte = flags_reg;
    end
  end

  // Every access costs exactly one wait cycle. The request is taken in
  // the idle state, and the edge that ends the acknowledge cycle is the one at which
  // a write lands; an unmapped access is answered the same way.
  always_comb begin
    bus_next = bus_reg;
    readdata_next = readdata_reg;
    unique case (bus_reg)
      SVM_IDLE: begin
        if (avs_read || avs_write) begin
          bus_next = SVM_ACK;
          if (avs_read) begin
            readdata_next = {SVM_PAD, rd_byte};
          end
        end
      end
      SVM_ACK: begin
        bus_next = SVM_IDLE;
      end
    endcase
    waitrequest_next = (bus_next == SVM_IDLE);
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_reg <= SVM_IDLE;
      waitrequest_reg <= 1'b1;
      readdata_reg <= SVM_DATA_RESET;
    end else begin
      bus_reg <= bus_next;
      waitrequest_reg <= waitrequest_next;
      readdata_reg <= readdata_next;
    end
  end

  // Only byte lane 0 carries register bits; other lanes are ignored.
  assign wr_fire = avs_write && (bus_reg == SVM_ACK) &&
                   avs_byteenable[SVM_LANE0];
  assign wr_byte = avs_writedata[SVM_REG_W-1:0];

  // Flag update. A change seen in the same cycle as a clearing write
  // still sets the flag, so no event is lost. Stop mode has no term here,
  // which keeps the flags across it.
  always_comb begin
    clr_mask = SVM_REG_RESET;
    if (wr_fire && hits(avs_address, SVM_IDX_FLAGS)) begin
      clr_mask = wr_byte & SVM_IRQ_MASK;
    end
    set_mask = SVM_REG_RESET;
    set_mask[SVM_LOW_BIT] = cond_if.change[SVM_LOW_BIT];
    set_mask[SVM_HIGH_BIT] = cond_if.change[SVM_HIGH_BIT];
    flags_next = (flags_reg & ~clr_mask) | set_mask;
  end

  // Control registers. Threshold selects go straight to the comparators;
  // the status bits have no write path at all.
  always_comb begin
    enable_next = enable_reg;
    irq_en_next = irq_en_reg;
    if (wr_fire && hits(avs_address, SVM_IDX_ENABLE)) begin
      enable_next = wr_byte & SVM_ENABLE_MASK;
    end
    if (wr_fire && hits(avs_address, SVM_IDX_IRQ_EN)) begin
      irq_en_next = wr_byte & SVM_IRQ_MASK;
    end
  end

  // Interrupt merge. Registered so the pin comes from a flip-flop; this
  // costs one cycle of latency after a flag or enable changes.
  always_comb begin
    irq_next = 1'b0;
    if (flags_reg[SVM_LOW_BIT] && irq_en_reg[SVM_LOW_BIT]) begin
      irq_next = 1'b1;
    end
    if (flags_reg[SVM_HIGH_BIT] && irq_en_reg[SVM_HIGH_BIT]) begin
      irq_next = 1'b1;
    end
    if (cpu_stop_mode) begin
      irq_next = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      enable_reg <= SVM_REG_RESET;
      irq_en_reg <= SVM_REG_RESET;
      flags_reg <= SVM_REG_RESET;
      irq_reg <= 1'b0;
    end else begin
      enable_reg <= enable_next;
      irq_en_reg <= irq_en_next;
      flags_reg <= flags_next;
      irq_reg <= irq_next;
    end
  end

  // Outputs, all straight from flip-flops.
  assign avs_readdata = readdata_reg;
  assign avs_waitrequest = waitrequest_reg;
  assign low_threshold_select =
    enable_reg[SVM_LOW_SEL_MSB:SVM_LOW_SEL_LSB];
  assign high_threshold_select = enable_reg[SVM_HIGH_SEL_BIT];
  assign level_sense_enable = enable_reg[SVM_SENSE_EN_BIT];
  assign adc_connect_enable = enable_reg[SVM_ADC_EN_BIT];
  assign module_irq = irq_reg;

endmodule

// ==== tb/svm_top_assertions.sv ====
`timescale 1ns/1ps
module svm_chk (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Register bus.
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Controls and interrupt.
  input wire logic level_sense_enable,
  input wire logic cpu_stop_mode,
  input wire logic module_irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic ack_wr;
  // A write that lands on lane 0 at the acknowledging edge.
  assign ack_wr = avs_write && !avs_waitrequest && avs_byteenable[0];
  a_stop_irq_low: assert property (cpu_stop_mode |=> !module_irq)
    else $error("Interrupt seen in stop mode.");
  a_ack_one: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("Acknowledge longer than one cycle.");
  a_ack_prompt: assert property
    ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("Access not answered in one cycle.");
  a_pad_zero: assert property
    (!avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000)
    else $error("Upper read bits not zero.");
  a_unmapped_zero: assert property
    (avs_read && avs_waitrequest && avs_address[4] |=> avs_readdata == 0)
    else $error("Unmapped read not zero.");
  a_sense_off: assert property (!level_sense_enable [*3] ##0
    (avs_read && avs_waitrequest && avs_address == 5'h04)
    |=> avs_readdata[1:0] == 2'h0) else $error("Condition while sense off.");
  a_sense_bit: assert property (ack_wr && avs_address == 5'h00
    |=> level_sense_enable == $past(avs_writedata[2]))
    else $error("Sense enable not taken from bit two.");
  a_irq_off: assert property (ack_wr && avs_address == 5'h08
    && avs_writedata[1:0] == 2'h0 |-> ##2 !module_irq)
    else $error("Interrupt with both enables clear.");
  a_rdata_hold: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("Read data changed without a read.");
endmodule
bind svm_top svm_chk svm_chk_i (.ref_clk, .sys_rst, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
  .avs_waitrequest, .level_sense_enable, .cpu_stop_mode, .module_irq);

// ==== tb/svm_analog_model.sv ====
`timescale 1ns/1ps
module svm_analog_model #(
  parameter int LOW_MV [4] = '{3000, 3500, 4000, 4500},
  parameter int HIGH_MV [2] = '{7000, 8000}
) (
  // Supply level in millivolts.
  input wire logic [15:0] supply_mv,
  // Trip level selects.
  input wire logic [1:0] low_threshold_select,
  input wire logic high_threshold_select,
  // Raw comparator results.
  output logic low_cmp_in,
  output logic high_cmp_in
);
  // The delay keeps comparator edges off the clock; no hysteresis is modelled.
  assign #7 low_cmp_in = supply_mv < LOW_MV[low_threshold_select];
  assign #7 high_cmp_in = supply_mv >= HIGH_MV[high_threshold_select];
endmodule

// ==== tb/supply_voltage_monitor_irq_tb.sv ====
`timescale 1ns/1ps
module supply_voltage_monitor_irq_tb;
  import svm_pkg::*;
  localparam int LOW_MV [4] = '{3000, 3500, 4000, 4500};
  localparam int HIGH_MV [2] = '{7000, 8000};
  logic ref_clk, sys_rst, avs_read, avs_write, cpu_stop_mode, module_irq;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q, r;
  logic [3:0] avs_byteenable;
  logic avs_waitrequest, low_cmp_in, high_cmp_in, high_threshold_select;
  logic [1:0] low_threshold_select;
  logic level_sense_enable, adc_connect_enable;
  logic [15:0] supply_mv;
  logic [7:0] ens, ie, flags, cond;
  int fail_count, num_checks;
  svm_top svm_top_i (.ref_clk, .sys_rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .low_cmp_in, .high_cmp_in, .low_threshold_select, .high_threshold_select,
    .level_sense_enable, .adc_connect_enable, .cpu_stop_mode, .module_irq);
  svm_analog_model #(.LOW_MV(LOW_MV), .HIGH_MV(HIGH_MV)) svm_analog_model_i (
    .supply_mv, .low_threshold_select, .high_threshold_select, .low_cmp_in,
    .high_cmp_in);
  // Free running 50 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask
  task finish_test;
    $display("Checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // One bus access; the request is held until waitrequest is sampled low,
  // however long that takes, so only the watchdog can end a stuck wait.
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d,
           input logic [3:0] b);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= b;
    avs_read <= !w;
    avs_write <= w;
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // Enough edges for sync, condition, flag and interrupt stages.
  task settle;
    repeat (8) @(posedge ref_clk);
  endtask
  // Reference conditions for sense bit s with the trip levels of e.
  function automatic logic [7:0] cnd(input logic s, input logic [7:0] e);
    cnd = {6'h0, s && supply_mv >= HIGH_MV[e[6]],
           s && supply_mv < LOW_MV[e[5:4]]};
  endfunction
  // Any change of a condition sets its flag; flags are sticky.
  task upd(input logic [7:0] v);
    flags |= v ^ cond;
    cond = v;
  endtask
  // Main sequence; enables are software's and may break the off order.
  initial begin
    {avs_read, avs_write, cpu_stop_mode, avs_address} = 0;
    {avs_writedata, avs_byteenable, ens, ie, flags, cond} = 0;
    supply_mv = 16'd5000;
    sys_rst = 1'b1;
    fail_count = 0;
    num_checks = 0;
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    void'($urandom(37));
    for (int a = 0; a < 6; a++) begin
      bus(1'b0, 5'(a * 4), 0, 4'h1);
      check(q, 0);
    end
    bus(1'b1, 5'h14, 32'hff, 4'hf);
    for (int i = 0; i < 40; i++) begin
      r = $urandom;
      bus(1'b1, 5'h00, r, 4'h1);
      // The sense bit gates at once but the comparators lag two cycles,
      // so a fresh enable first judges the supply by the old trip levels.
      upd(cnd(r[2], ens));
      ens = r[7:0] & SVM_ENABLE_MASK;
      settle;
      upd(cnd(ens[2], ens));
      supply_mv <= 16'(2000 + $urandom % 7000);
      settle;
      upd(cnd(ens[2], ens));
      ie = 8'($urandom) & SVM_IRQ_MASK;
      bus(1'b1, 5'h08, 32'(ie), 4'h1);
      bus(1'b1, 5'h04, $urandom, 4'hf);
      cpu_stop_mode <= 1'($urandom);
      settle;
      bus(1'b0, 5'h00, 0, 4'h1);
      check(q, 32'(ens));
      check({high_threshold_select, low_threshold_select, adc_connect_enable,
             level_sense_enable}, 32'(ens[6:2]));
      bus(1'b0, 5'h04, 0, 4'h1);
      check(q, 32'(cond));
      bus(1'b0, 5'h0c, 0, 4'h1);
      check(q, 32'(flags));
      check(module_irq,
            (|(flags & ie)) && !cpu_stop_mode);
      r = $urandom;
      bus(1'b1, 5'h0c, r, r[11:8]);
      if (r[8])
        flags &= ~r[7:0];
    end
    // Orderly shutdown: interrupt enables first, then sensing, so the
    // forced condition drop sets flags but raises no request.
    cpu_stop_mode <= 1'b0;
    ie = 8'h00;
    bus(1'b1, 5'h08, 0, 4'h1);
    bus(1'b1, 5'h00, 0, 4'h1);
    upd(8'h00);
    ens = 8'h00;
    settle;
    check(module_irq, 0);
    bus(1'b0, 5'h0c, 0, 4'h1);
    check(q, 32'(flags));
    finish_test;
  end
  // Watchdog well beyond the expected run length.
  initial begin
    #500us;
    fail_count++;
    finish_test;
  end
endmodule
